// [src/reset_cause_defines.svh]
// Holds offsets, bit positions and reset values of the reset-cause register.
// Assumes inclusion by bare name from the design module.
`ifndef RESET_CAUSE_DEFINES_SVH
`define RESET_CAUSE_DEFINES_SVH
`define RCS_OFFSET 12'h000
`define RCS_TRAP_BIT 15
`define RCS_ILLOP_BIT 14
`define RCS_FLASH_REG_BIT 11
`define RCS_UNIMP_BIT 10
`define RCS_CFGMIS_BIT 9
`define RCS_CORE_REG_BIT 8
`define RCS_PIN_BIT 7
`define RCS_SOFT_BIT 6
`define RCS_WDT_EN_BIT 5
`define RCS_WATCHDOG_TIMEOUT_FLAG_BIT 4
`define RCS_RESET_VAL 16'h0000
`define RCS_WMASK 16'hCBF0
`endif

// [src/reset_cause_pkg.sv]
// Holds the types shared by the reset-cause register block.
// Assumes the defines header is on the include path.
`default_nettype none
package reset_cause_pkg;
    // Reset events from the reset unit, one-cycle pulses
    typedef struct packed {
        logic trap_conflict;
        logic illegal_op;
        logic config_mismatch;
        logic master_clear_pin;
        logic soft_reset;
        logic watchdog_timeout;
    } reset_events_t;
    // Control levels driven from the register; watchdog enable is also forced on by the fuse
    typedef struct packed {
        logic flash_reg_sleep_active;
        logic core_reg_sleep_active;
        logic watchdog_enabled;
    } reg_ctrl_t;
endpackage : reset_cause_pkg
`default_nettype wire

// [src/reset_cause_status.sv]
// Holds the reset-cause status register as an APB slave.
// Assumes event pulses synchronous to pclk; fuse level comes from a pin.
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`include "reset_cause_defines.svh"
`default_nettype none
module reset_cause_status (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Reset events, same clock
    input wire reset_cause_pkg::reset_events_t events,
    // Watchdog fuse, asynchronous pin
    input wire logic watchdog_fuse_enable,
    // Control outputs
    output reset_cause_pkg::reg_ctrl_t ctrl
);
    import reset_cause_pkg::*;

    // ********************************
    // Declarations
    // ********************************
    logic [15:0] reg_ff;
    logic [15:0] nxt_reg;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic fuse_meta_ff;
    logic fuse_ff;
    logic sel_hit;
    logic wr_en;
    logic [15:0] wbyte_mask;

    // ********************************
    // Bus decode
    // ********************************
    // Single-cycle access, unmapped address errors
    assign sel_hit = (paddr == `RCS_OFFSET);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~sel_hit;
    assign wr_en = psel & penable & pwrite & sel_hit;
    assign wbyte_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    assign prdata = prdata_ff;

    // Fuse synchroniser
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fuse_meta_ff <= 1'b0;
            fuse_ff <= 1'b0;
        end
        else
        begin
            fuse_meta_ff <= watchdog_fuse_enable;
            fuse_ff <= fuse_meta_ff;
        end
    end

    // ********************************
    // Register update
    // ********************************
    // Write first, then hardware events win over clears
    always_comb
    begin
        nxt_reg = reg_ff;
        if (wr_en)
        begin
            nxt_reg = (reg_ff & ~(wbyte_mask & `RCS_WMASK)) |
                      (pwdata[15:0] & wbyte_mask & `RCS_WMASK);
        end
        if (events.trap_conflict)
        begin
            nxt_reg[`RCS_TRAP_BIT] = 1'b1;
        end
        if (events.illegal_op)
        begin
            nxt_reg[`RCS_ILLOP_BIT] = 1'b1;
        end
        if (events.config_mismatch)
        begin
            nxt_reg[`RCS_CFGMIS_BIT] = 1'b1;
        end
        if (events.master_clear_pin)
        begin
            nxt_reg[`RCS_PIN_BIT] = 1'b1;
        end
        if (events.soft_reset)
        begin
            nxt_reg[`RCS_SOFT_BIT] = 1'b1;
        end
        if (events.watchdog_timeout)
        begin
            nxt_reg[`RCS_WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b1;
        end
        nxt_reg[`RCS_UNIMP_BIT] = 1'b0;
    end

    // Read data capture
    always_comb
    begin
        nxt_prdata = prdata_ff;
        if (psel && !penable && !pwrite)
        begin
            nxt_prdata = sel_hit ? {16'h0000, reg_ff} : 32'h0000_0000;
        end
    end

    // Register storage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            reg_ff <= `RCS_RESET_VAL;
            prdata_ff <= 32'h0000_0000;
        end
        else
        begin
            reg_ff <= nxt_reg;
            prdata_ff <= nxt_prdata;
        end
    end

    // ********************************
    // Control outputs
    // ********************************
    // flash regulator select
    assign ctrl.flash_reg_sleep_active = reg_ff[`RCS_FLASH_REG_BIT];
    assign ctrl.core_reg_sleep_active = reg_ff[`RCS_CORE_REG_BIT];
    assign ctrl.watchdog_enabled = reg_ff[`RCS_WDT_EN_BIT] | fuse_ff;

    // ********************************
    // Assertions
    // ********************************
    property p_trap;
        @(posedge pclk) disable iff (!presetn)
        events.trap_conflict |=> reg_ff[`RCS_TRAP_BIT];
    endproperty
    a_trap: assert property (p_trap) else $error("trap flag not set");
    property p_illop;
        @(posedge pclk) disable iff (!presetn)
        events.illegal_op |=> reg_ff[`RCS_ILLOP_BIT];
    endproperty
    a_illop: assert property (p_illop) else $error("illop not set");
    property p_cfg;
        @(posedge pclk) disable iff (!presetn)
        events.config_mismatch |=> reg_ff[`RCS_CFGMIS_BIT];
    endproperty
    a_cfg: assert property (p_cfg) else $error("mismatch not set");
    property p_pin;
        @(posedge pclk) disable iff (!presetn)
        events.master_clear_pin |=> reg_ff[`RCS_PIN_BIT];
    endproperty
    a_pin: assert property (p_pin) else $error("pin flag not set");
    property p_soft;
        @(posedge pclk) disable iff (!presetn)
        events.soft_reset |=> reg_ff[`RCS_SOFT_BIT];
    endproperty
    a_soft: assert property (p_soft) else $error("soft flag not set");
    property p_watchdog_timeout_flag;
        @(posedge pclk) disable iff (!presetn)
        events.watchdog_timeout |=> reg_ff[`RCS_WATCHDOG_TIMEOUT_FLAG_BIT];
    endproperty
    a_watchdog_timeout_flag: assert property (p_watchdog_timeout_flag) else $error("watchdog_timeout_flag not set");
    property p_wr;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && pstrb[0] && !events.soft_reset) |=>
            reg_ff[`RCS_SOFT_BIT] == $past(pwdata[`RCS_SOFT_BIT]);
    endproperty
    a_wr: assert property (p_wr) else $error("write not kept");
    property p_unimp;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && sel_hit) |=>
            !prdata[`RCS_UNIMP_BIT];
    endproperty
    a_unimp: assert property (p_unimp) else $error("bit 10 not zero");
    property p_fuse;
        @(posedge pclk) disable iff (!presetn)
        fuse_ff |-> ctrl.watchdog_enabled;
    endproperty
    a_fuse: assert property (p_fuse) else $error("fuse ignored");
    property p_wden;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && pstrb[0]) |=> fuse_ff ||
            (ctrl.watchdog_enabled == $past(pwdata[`RCS_WDT_EN_BIT]));
    endproperty
    a_wden: assert property (p_wden) else $error("sw enable wrong");
    c_write: cover property (@(posedge pclk) wr_en);
    c_trap: cover property (@(posedge pclk) events.trap_conflict);
    c_err: cover property (@(posedge pclk) pslverr);
endmodule : reset_cause_status
`default_nettype wire

// [verif/reset_cause_status_tb.sv]
// Testbench for the reset-cause status register block.
// Assumes the design package and the APB slave module are compiled first.
`default_nettype none
module reset_cause_status_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import reset_cause_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, err, watchdog_fuse_enable = 0;
    reset_events_t events = '0;
    reg_ctrl_t ctrl;
    int bad_count = 0, checks_done = 0;
    logic [21:0] rows [6] = '{{6'h20, 16'h8000}, {6'h10, 16'h4000},
        {6'h08, 16'h0200}, {6'h04, 16'h0080}, {6'h02, 16'h0040},
        {6'h01, 16'h0010}};
    reset_cause_status i_reset_cause_status (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .events(events), .watchdog_fuse_enable(watchdog_fuse_enable),
        .ctrl(ctrl));
    // Clock 100 ns
    always #50 pclk = ~pclk;
    // Verdict and end
    task end_sim;
        if (bad_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim
    // Compare seen with expected
    task chk(input string n, input logic [31:0] s, input logic [31:0] x);
        checks_done++;
        if (s !== x)
        begin
            bad_count++;
            $display("MISMATCH %s exp %h seen %h", n, x, s);
        end
    endtask : chk
    // One APB transfer
    task apb(input logic w, input logic [11:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge pclk);
        end
        if (n == 20)
        begin
            bad_count++;
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    // Main sequence
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1;
        apb(0, 12'h000, 16'h0000);
        chk("reset value", rd, 32'h0000_0000);
        for (int i = 0; i < 6; i++)
        begin
            apb(1, 12'h000, 16'h0000);
            @(posedge pclk);
            events <= reset_events_t'(rows[i][21:16]);
            @(posedge pclk);
            events <= '0;
            apb(0, 12'h000, 16'h0000);
            chk("flag", rd, {16'h0, rows[i][15:0]});
        end
        apb(1, 12'h000, 16'hFFFF);
        apb(0, 12'h000, 16'h0000);
        chk("all ones", rd, 32'h0000_CBF0);
        chk("ctrl on", ctrl, 3'b111);
        apb(1, 12'h000, 16'h0000);
        apb(0, 12'h000, 16'h0000);
        chk("cleared", rd, 32'h0000_0000);
        chk("ctrl off", ctrl, 3'b000);
        // Unmapped address refused
        apb(1, 12'h004, 16'hFFFF);
        chk("slverr", err, 1'b1);
        apb(0, 12'h000, 16'h0000);
        chk("no side write", rd, 32'h0000_0000);
        // Unmapped read gives zero and an error
        apb(0, 12'h004, 16'h0000);
        chk("unmapped rd", rd, 32'h0000_0000);
        chk("unmapped err", err, 1'b1);
        // event beats a clearing write in the same cycle
        fork
            apb(1, 12'h000, 16'h0000);
            begin
                repeat (2) @(posedge pclk);
                events <= reset_events_t'(6'h20);
                @(posedge pclk);
                events <= '0;
            end
        join
        apb(0, 12'h000, 16'h0000);
        chk("set wins", rd, 32'h0000_8000);
        chk("mapped err", err, 1'b0);
        pstrb <= 4'h1;
        apb(1, 12'h000, 16'hFFFF);
        pstrb <= 4'hF;
        apb(0, 12'h000, 16'h0000);
        chk("low lane", rd, 32'h0000_80F0);
        // Mid-run reset clears register and controls
        presetn <= 0;
        repeat (2) @(posedge pclk);
        chk("ctrl in reset", ctrl, 3'b000);
        presetn <= 1;
        apb(0, 12'h000, 16'h0000);
        chk("after reset", rd, 32'h0000_0000);
        watchdog_fuse_enable <= 1;
        repeat (4) @(posedge pclk);
        chk("fuse", ctrl, 3'b001);
        end_sim();
    end
endmodule : reset_cause_status_tb
`default_nettype wire
